// ===== rtl/fhm_fault_history.sv
// fault history memory: last fault, ten entry history, parameter access
`timescale 1ns/1ps
`default_nettype none
module fhm_fault_history #(
    parameter int DEPTH = fhm_pkg::HISTORY_DEPTH, // history entries
    parameter logic [15:0] RT_FAULT_NUMBER = 16'h0001 // number for bad realtime data
) (
    input wire logic clk, // clock, 100 MHz
    input wire logic rst, // sync reset, factory state
    input wire logic powerCycle, // pulse: supply off/on, volatile state only
    input wire logic faultValid, // pulse: fault reported
    input wire logic [15:0] faultNumber, // reported error number
    input wire logic [2:0] faultClass, // reported class
    input wire logic [15:0] faultExtra, // reported extra information
    input wire logic [31:0] timeStamp, // current time value
    input wire logic faultAck, // pulse: fault acknowledge
    input wire logic rtWriteInvalid, // pulse: invalid realtime write
    input wire logic paramReq, // pulse: parameter access
    input wire logic paramWrite, // 1 write, 0 read
    input wire logic [15:0] paramAddr, // parameter address
    input wire logic [31:0] paramWdata, // write value
    output logic paramBusy, // access in progress
    output logic paramAck, // pulse: access done
    output logic paramErr, // with ack: access refused
    output logic [31:0] paramRdata, // with ack: read value
    output logic [15:0] lastFaultNumber, // last fault number
    output logic quickStop, // quick stop reaction active
    output logic rtWriteDiscard // pulse: realtime write dropped
);

    localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1; // index width
    localparam int CNT_W = $clog2(DEPTH + 1); // count width
    localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH); // full count
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1); // top index
    localparam int CLEAR_MAX = 16; // bound on wipe length in cycles

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [CNT_W-1:0] count; // stored entries, persistent
    logic [IDX_W-1:0] head; // index of oldest entry, persistent
    logic [CNT_W-1:0] readPtr; // next position to fetch, 0 is oldest
    logic behaviour; // realtime error setting, persistent
    logic [2:0] lastClass; // class of last fault
    fhm_pkg::fhm_entry_t holdBuf; // entry latched by number read
    fhm_pkg::fhm_req_t reqQ; // captured access
    fhm_pkg::fhm_clear_state_t clearState; // clear sequencer
    logic [IDX_W-1:0] wipeIdx; // entry being zeroed
    fhm_pkg::fhm_entry_t memRd; // entry at readPtr
    logic rtFault; // class one request from guard

    // ring position to array index
    function automatic logic [IDX_W-1:0] wrapIdx(input logic [IDX_W-1:0] base,
                                                   input logic [CNT_W-1:0] off);
        logic [CNT_W:0] sum;
        sum = (CNT_W+1)'(base) + (CNT_W+1)'(off);
        if (sum >= (CNT_W+1)'(DEPTH)) begin
            sum = sum - (CNT_W+1)'(DEPTH);
        end
        return IDX_W'(sum);
    endfunction : wrapIdx

    ////////////////////////////////////////////////////////////////////////////
    // fault intake
    wire extValid = faultValid && (faultNumber != fhm_pkg::NO_FAULT); // real fault
    wire selValid = extValid || rtFault; // any fault this cycle
    wire [15:0] selNumber = extValid ? faultNumber : RT_FAULT_NUMBER; // chosen number
    wire [2:0] selClass = extValid ? faultClass : fhm_pkg::CLASS_QSTOP; // chosen class
    wire newFault = selValid && (lastFaultNumber == fhm_pkg::NO_FAULT); // RL2
    wire clearing = (clearState != fhm_pkg::CLR_IDLE); // wipe running
    wire record = newFault && !clearing; // store the originating fault
    wire isFull = (count == FULL); // history full
    wire ackClears = faultAck && (lastClass != fhm_pkg::CLASS_FATAL_LOCKED); // RL18
    wire fhm_pkg::fhm_entry_t newEntry = '{number: selNumber, cls: selClass,
                                          stamp: timeStamp, extra: faultExtra}; // RL14
    wire [IDX_W-1:0] recIdx = isFull ? head : wrapIdx(head, count); // RL19
    wire [IDX_W-1:0] nextHead = (head == LAST_IDX) ? '0 : head + 1'b1; // oldest moves on

    ////////////////////////////////////////////////////////////////////////////
    // access decode
    wire reqTake = paramReq && !paramBusy; // request accepted
    wire hitClear = (reqQ.addr == fhm_pkg::ADDR_CLEAR); // history_clear
    wire hitPtr = (reqQ.addr == fhm_pkg::ADDR_PTR_RESET); // history_pointer_reset
    wire hitNum = (reqQ.addr == fhm_pkg::ADDR_ERR_NUM); // entry_error_number
    wire hitClass = (reqQ.addr == fhm_pkg::ADDR_CLASS); // entry_class
    wire hitTime = (reqQ.addr == fhm_pkg::ADDR_TIME); // entry_time
    wire hitExtra = (reqQ.addr == fhm_pkg::ADDR_EXTRA); // entry_extra_info
    wire hitBehv = (reqQ.addr == fhm_pkg::ADDR_BEHAVIOUR); // realtime_error_behaviour
    wire wrOne = (reqQ.wdata == fhm_pkg::CMD_ONE); // value one
    wire wrZero = (reqQ.wdata == fhm_pkg::CMD_ZERO); // value zero
    wire doRd = paramBusy && !reqQ.write; // read in stage
    wire doWr = paramBusy && reqQ.write; // write in stage
    wire startClear = doWr && hitClear && wrOne && !clearing; // RL4
    wire rewindPtr = doWr && hitPtr && wrOne; // RL6
    wire entryLeft = (readPtr < count); // RL9
    wire fetchNum = doRd && hitNum; // RL11
    wire setBehv = doWr && hitBehv && (wrOne || wrZero); // RL17
    wire cmdWrOk = (hitClear || hitPtr) && (wrOne || wrZero); // command writes
    wire wrOk = cmdWrOk || (hitBehv && (wrOne || wrZero)); // legal write
    wire rdOk = hitClear || hitPtr || hitNum || hitClass || hitTime || hitExtra || hitBehv;
    wire next_paramErr = reqQ.write ? !wrOk : !rdOk; // refused access
    wire [15:0] fetchedNum = entryLeft ? memRd.number : fhm_pkg::NO_FAULT; // RL9
    wire [31:0] next_paramRdata =
        reqQ.write ? '0 :
        hitClear ? {31'h00000000, clearing} : // RL5
        hitNum ? {16'h0000, fetchedNum} :
        hitClass ? {29'h00000000, holdBuf.cls} : // RL13
        hitTime ? holdBuf.stamp : // RL20
        hitExtra ? {16'h0000, holdBuf.extra} : // RL14
        hitBehv ? {31'h00000000, behaviour} : '0; // pointer reset reads zero

    ////////////////////////////////////////////////////////////////////////////
    // memory ports
    wire memWr = (clearState == fhm_pkg::CLR_WIPE) || record; // one writer at a time
    wire [IDX_W-1:0] memWrAddr = clearing ? wipeIdx : recIdx; // wipe or record slot
    wire fhm_pkg::fhm_entry_t memWrData = clearing ? '0 : newEntry; // zero or new
    wire [IDX_W-1:0] memRdAddr = wrapIdx(head, readPtr); // RL10

    fhm_mem #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_mem (
        .clk(clk),
        .rst(rst),
        .wrEn(memWr),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddr(memRdAddr),
        .rdData(memRd)
    );

    fhm_rt_guard u_guard (
        .clk(clk),
        .rst(rst),
        .invalidWrite(rtWriteInvalid),
        .behaviour(behaviour),
        .discard(rtWriteDiscard),
        .faultReq(rtFault)
    );

    ////////////////////////////////////////////////////////////////////////////
    // access stage: capture, then answer one cycle later
    always_ff @(posedge clk) begin
        if (rst || powerCycle) begin
            paramBusy <= 1'b0; // idle
            reqQ <= '0; // empty
            paramAck <= 1'b0; // no answer
            paramErr <= 1'b0; // no error
            paramRdata <= '0; // no data
        end else begin
            paramBusy <= reqTake; // busy for one cycle
            if (reqTake) begin
                reqQ <= '{write: paramWrite, addr: paramAddr, wdata: paramWdata};
            end
            paramAck <= paramBusy; // answer pulse
            paramErr <= paramBusy && next_paramErr; // refused
            paramRdata <= paramBusy ? next_paramRdata : '0; // read value
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read pointer and holding buffer
    always_ff @(posedge clk) begin
        if (rst || powerCycle || clearState == fhm_pkg::CLR_FINISH) begin
            readPtr <= '0; // start at oldest
        end else if (rewindPtr) begin
            readPtr <= '0; // RL6
        end else if (fetchNum && entryLeft) begin
            readPtr <= readPtr + 1'b1; // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (rst || powerCycle) begin
            holdBuf <= '0; // empty buffer
        end else if (fetchNum) begin
            holdBuf <= entryLeft ? memRd : '0; // RL11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // history ring bookkeeping
    always_ff @(posedge clk) begin
        if (rst || clearState == fhm_pkg::CLR_FINISH) begin
            count <= '0; // empty history
            head <= '0; // oldest at slot zero
        end else if (record) begin
            if (isFull) begin
                head <= nextHead; // RL19
            end else begin
                count <= count + 1'b1; // RL3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            clearState <= fhm_pkg::CLR_IDLE; // idle
            wipeIdx <= '0; // first slot
        end else begin
            unique case (clearState)
                fhm_pkg::CLR_IDLE: begin
                    wipeIdx <= '0; // restart wipe
                    if (startClear) begin
                        clearState <= fhm_pkg::CLR_WIPE; // RL4
                    end
                end
                fhm_pkg::CLR_WIPE: begin
                    wipeIdx <= wipeIdx + 1'b1; // next slot
                    if (wipeIdx == LAST_IDX) begin
                        clearState <= fhm_pkg::CLR_FINISH; // all zeroed
                    end
                end
                fhm_pkg::CLR_FINISH: begin
                    clearState <= fhm_pkg::CLR_IDLE; // RL5
                end
                default: begin
                    clearState <= fhm_pkg::CLR_IDLE; // illegal code
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // last fault, setting and reaction
    always_ff @(posedge clk) begin
        if (rst || powerCycle) begin
            lastFaultNumber <= fhm_pkg::NO_FAULT; // RL1
            lastClass <= fhm_pkg::CLASS_WARNING; // none
        end else if (newFault) begin
            lastFaultNumber <= selNumber; // set wins over acknowledge
            lastClass <= selClass; // class of this fault
        end else if (ackClears) begin
            lastFaultNumber <= fhm_pkg::NO_FAULT; // RL18
            lastClass <= fhm_pkg::CLASS_WARNING; // none
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            behaviour <= fhm_pkg::BEHAVIOUR_RESET; // RL15
        end else if (setBehv) begin
            behaviour <= reqQ.wdata[0]; // RL17
        end
    end

    wire stopClass = (lastClass == fhm_pkg::CLASS_QSTOP) ||
                     (lastClass == fhm_pkg::CLASS_QSTOP_FAULT); // quick stop classes
    always_ff @(posedge clk) begin
        if (rst) begin
            quickStop <= 1'b0; // no reaction
        end else begin
            quickStop <= (lastFaultNumber != fhm_pkg::NO_FAULT) && stopClass; // RL16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_clear_done;
        @(posedge clk) disable iff (rst)
        startClear |=> clearing ##[1:CLEAR_MAX] (!clearing && count == '0);
    endproperty
    a_clear_done: assert property (p_clear_done) // RL4
        else $error("clear did not empty the history");

    property p_clear_busy_read;
        @(posedge clk) disable iff (rst || powerCycle)
        (doRd && hitClear && clearing) |=> (paramAck && paramRdata != '0);
    endproperty
    a_clear_busy_read: assert property (p_clear_busy_read) // RL5
        else $error("clear read zero while clearing");

    property p_rewind;
        @(posedge clk) disable iff (rst || powerCycle)
        (reqTake && paramWrite && paramAddr == fhm_pkg::ADDR_PTR_RESET
         && paramWdata == fhm_pkg::CMD_ONE) |-> ##2 (readPtr == '0);
    endproperty
    a_rewind: assert property (p_rewind) // RL6
        else $error("pointer not rewound");

    property p_advance;
        @(posedge clk) disable iff (rst || powerCycle || clearing)
        (fetchNum && entryLeft && !rewindPtr) |=> (readPtr == $past(readPtr) + 1'b1);
    endproperty
    a_advance: assert property (p_advance) // RL8
        else $error("pointer did not advance");

    property p_end_mark;
        @(posedge clk) disable iff (rst || powerCycle)
        (fetchNum && !entryLeft) |=> (paramAck && paramRdata == '0 && holdBuf == '0);
    endproperty
    a_end_mark: assert property (p_end_mark) // RL9
        else $error("end of history not zero");

    property p_buffer_class;
        @(posedge clk) disable iff (rst || powerCycle)
        (doRd && hitClass) |=> (paramRdata[2:0] == $past(holdBuf.cls));
    endproperty
    a_buffer_class: assert property (p_buffer_class) // RL11
        else $error("class not served from buffer");

    property p_first_only;
        @(posedge clk) disable iff (rst || powerCycle)
        (selValid && lastFaultNumber != fhm_pkg::NO_FAULT && !clearing)
        |=> $stable(count) && $stable(head);
    endproperty
    a_first_only: assert property (p_first_only) // RL2
        else $error("consequential fault was stored");

    property p_drop_oldest;
        @(posedge clk) disable iff (rst)
        (record && isFull) |=> (count == FULL && head == $past(nextHead));
    endproperty
    a_drop_oldest: assert property (p_drop_oldest) // RL19
        else $error("full history did not drop oldest");

    property p_locked;
        @(posedge clk) disable iff (rst || powerCycle)
        (faultAck && lastClass == fhm_pkg::CLASS_FATAL_LOCKED)
        |=> (lastFaultNumber != fhm_pkg::NO_FAULT) [*2];
    endproperty
    a_locked: assert property (p_locked) // RL18
        else $error("class four cleared by acknowledge");

endmodule : fhm_fault_history
`default_nettype wire

// ===== rtl/fhm_pkg.sv
// shared constants and types of the fault history memory
// Behaviour
// RL1: last fault number reads zero without fault
// RL2: only the first fault of a chain recorded
// RL3: ten newest entries kept across power loss
// RL4: writing one to clear wipes the history
// RL5: clear reads nonzero until wipe completes
// RL6: writing one to pointer reset rewinds pointer
// RL7: master reads history strictly in sequence
// RL8: pointer advances by itself after each fetch
// RL9: fetch past last entry returns number zero
// RL10: position one oldest, position ten newest
// RL11: number read latches whole entry into buffer
// RL12: master reads number before other fields
// RL13: class codes zero to four as defined
// RL14: extra information is a 16-bit value
// RL15: setting zero discards bad writes silently
// RL16: setting one raises class one, quick stop
// RL17: setting picks class, survives power cycles
// RL18: class four needs supply cycle to clear
// RL19: full history drops oldest for newest entry
// RL20: time field is 32 bits from buffer
package fhm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // parameter addresses
    localparam logic [15:0] ADDR_BEHAVIOUR = 16'h190c; // realtime_error_behaviour
    localparam logic [15:0] ADDR_CLEAR = 16'h3b08; // history_clear
    localparam logic [15:0] ADDR_PTR_RESET = 16'h3b0a; // history_pointer_reset
    localparam logic [15:0] ADDR_ERR_NUM = 16'h3c02; // entry_error_number
    localparam logic [15:0] ADDR_CLASS = 16'h3c04; // entry_class
    localparam logic [15:0] ADDR_TIME = 16'h3c06; // entry_time
    localparam logic [15:0] ADDR_EXTRA = 16'h3c08; // entry_extra_info

    ////////////////////////////////////////////////////////////////////////////
    // values and sizes
    localparam int HISTORY_DEPTH = 10; // stored entries
    localparam logic [31:0] CMD_ONE = 32'h00000001; // command value
    localparam logic [31:0] CMD_ZERO = 32'h00000000; // idle value
    localparam logic [15:0] NO_FAULT = 16'h0000; // no fault / end mark
    localparam logic BEHAVIOUR_RESET = 1'b0; // factory setting
    localparam logic [2:0] CLASS_WARNING = 3'h0; // no reaction
    localparam logic [2:0] CLASS_QSTOP = 3'h1; // quick stop, state 7
    localparam logic [2:0] CLASS_QSTOP_FAULT = 3'h2; // quick stop, states 8, 9
    localparam logic [2:0] CLASS_FATAL_ACK = 3'h3; // state 9, acknowledgeable
    localparam logic [2:0] CLASS_FATAL_LOCKED = 3'h4; // state 9, supply cycle only

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic [15:0] number; // error number
        logic [2:0] cls; // error class
        logic [31:0] stamp; // time of occurrence
        logic [15:0] extra; // additional information
    } fhm_entry_t;

    typedef struct packed {
        logic write; // 1 write, 0 read
        logic [15:0] addr; // parameter address
        logic [31:0] wdata; // write value
    } fhm_req_t;

    typedef enum logic [1:0] {
        CLR_IDLE = 2'b00, // no clear running
        CLR_WIPE = 2'b01, // zeroing entries
        CLR_FINISH = 2'b11 // dropping count and pointers
    } fhm_clear_state_t;

endpackage : fhm_pkg

// ===== rtl/fhm_mem.sv
// entry storage of the fault history, registered read
`timescale 1ns/1ps
`default_nettype none
module fhm_mem #(
    parameter int DEPTH = fhm_pkg::HISTORY_DEPTH, // entries
    parameter int IDX_W = 4 // index width
) (
    input wire logic clk, // clock
    input wire logic rst, // clears read register only
    input wire logic wrEn, // write strobe
    input wire logic [IDX_W-1:0] wrAddr, // write index
    input wire fhm_pkg::fhm_entry_t wrData, // write entry
    input wire logic [IDX_W-1:0] rdAddr, // read index
    output fhm_pkg::fhm_entry_t rdData // entry, one cycle after address
);

    // array has no reset: contents model the persistent store
    fhm_pkg::fhm_entry_t store [DEPTH]; // entry array

    ////////////////////////////////////////////////////////////////////////////
    // write port
    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData; // RL3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read register
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= '0; // defined after reset
        end else begin
            rdData <= store[rdAddr]; // registered read
        end
    end

endmodule : fhm_mem
`default_nettype wire

// ===== rtl/fhm_rt_guard.sv
// handling of invalid realtime writes by the behaviour setting
`timescale 1ns/1ps
`default_nettype none
module fhm_rt_guard (
    input wire logic clk, // clock
    input wire logic rst, // sync reset
    input wire logic invalidWrite, // pulse: bad realtime write seen
    input wire logic behaviour, // 0 warning, 1 class one
    output logic discard, // pulse: write not executed
    output logic faultReq // pulse: raise class one fault
);

    ////////////////////////////////////////////////////////////////////////////
    // decision
    wire raiseFault = invalidWrite && behaviour; // RL16

    always_ff @(posedge clk) begin
        if (rst) begin
            discard <= 1'b0; // idle
            faultReq <= 1'b0; // idle
        end else begin
            discard <= invalidWrite; // RL15
            faultReq <= raiseFault; // RL17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_warn_silent;
        @(posedge clk) disable iff (rst)
        (invalidWrite && !behaviour) |=> (discard && !faultReq);
    endproperty
    a_warn_silent: assert property (p_warn_silent) // RL15
        else $error("warning setting raised a fault");

    property p_class_one;
        @(posedge clk) disable iff (rst)
        (invalidWrite && behaviour) |=> (faultReq && discard);
    endproperty
    a_class_one: assert property (p_class_one) // RL16
        else $error("class one setting raised no fault");

endmodule : fhm_rt_guard
`default_nettype wire

// ===== test/fhm_master_model.sv
// fieldbus master model issuing parameter accesses
`timescale 1ns/1ps
`default_nettype none
module fhm_master_model (
    input wire logic clk, // clock
    input wire logic paramAck, // answer strobe
    input wire logic paramErr, // answer refused
    input wire logic [31:0] paramRdata, // answer data
    output logic paramReq, // request strobe
    output logic paramWrite, // 1 write
    output logic [15:0] paramAddr, // address
    output logic [31:0] paramWdata // write value
);
    ////////////////////////////////////////////////////////////////////////////
    // idle bus at start
    initial begin
        paramReq = 1'b0;
        paramWrite = 1'b0;
        paramAddr = 16'h0000;
        paramWdata = 32'h00000000;
    end

    int lastWait = 0; // negedges waited for the last answer

    // one access, answer sampled mid ack cycle
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic er);
        int n;
        @(negedge clk);
        paramReq = 1'b1;
        paramWrite = wr;
        paramAddr = a;
        paramWdata = wd;
        @(negedge clk);
        paramReq = 1'b0;
        n = 0;
        // bounded wait for the answer
        while (paramAck !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        lastWait = n;
        rd = (n < 8) ? paramRdata : 32'hxxxxxxxx;
        er = paramErr;
        paramAddr = ~a; // released lines do not keep old value
        paramWdata = ~wd;
    endtask : access
endmodule : fhm_master_model
`default_nettype wire

// ===== test/tb_fhm_fault_history.sv
// testbench of the fault history memory
`timescale 1ns/1ps
`default_nettype none
module tb_fhm_fault_history;
    logic clk, rst, powerCycle, faultValid, faultAck, rtWriteInvalid; // drives
    logic [15:0] faultNumber, faultExtra, lastFaultNumber; // fault data
    logic [2:0] faultClass; // fault class
    logic [31:0] timeStamp, paramWdata, paramRdata, d; // data
    logic paramReq, paramWrite, paramBusy, paramAck, paramErr, quickStop, rtWriteDiscard, er;
    logic [15:0] paramAddr; // address
    int fails = 0; // mismatches
    int samplesChecked = 0; // comparisons

    ////////////////////////////////////////////////////////////////////////////
    // design, master, clock
    fhm_fault_history fhm_fault_history_i (.clk, .rst, .powerCycle, .faultValid, .faultNumber,
        .faultClass, .faultExtra, .timeStamp, .faultAck, .rtWriteInvalid, .paramReq,
        .paramWrite, .paramAddr, .paramWdata, .paramBusy, .paramAck, .paramErr, .paramRdata,
        .lastFaultNumber, .quickStop, .rtWriteDiscard);
    fhm_master_model fhm_master_model_i (.clk, .paramAck, .paramErr, .paramRdata, .paramReq,
        .paramWrite, .paramAddr, .paramWdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        fhm_master_model_i.access(1'b0, a, 32'h0, d, er);
        check(d, e);
        check({31'h0, er}, 32'h0);
        // answer one cycle after take, stage free again in the ack cycle
        check(fhm_master_model_i.lastWait, 32'h1);
        check({31'h0, paramBusy}, 32'h0);
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic e);
        fhm_master_model_i.access(1'b1, a, v, d, er);
        check({31'h0, er}, {31'h0, e});
        check(fhm_master_model_i.lastWait, 32'h1);
        check({31'h0, paramBusy}, 32'h0);
    endtask : wr
    // fault with derived extra and time
    task automatic fault(input logic [15:0] n, input logic [2:0] c);
        @(negedge clk);
        {faultValid, faultNumber, faultClass} = {1'b1, n, c};
        {faultExtra, timeStamp} = {n ^ 16'h5a5a, n, ~n};
        @(negedge clk);
        faultValid = 1'b0;
    endtask : fault
    // one cycle of power cycle, ack, bad realtime write
    task automatic pulse3(input logic [2:0] m);
        @(negedge clk);
        {powerCycle, faultAck, rtWriteInvalid} = m;
        @(negedge clk);
        {powerCycle, faultAck, rtWriteInvalid} = 3'b000;
    endtask : pulse3
    task finish_test;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test;
    end

    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        {rst, powerCycle, faultValid, faultAck, rtWriteInvalid} = 5'b10000;
        {faultNumber, faultExtra, faultClass, timeStamp} = '0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check({16'h0, lastFaultNumber}, 32'h0);
        rd(fhm_pkg::ADDR_BEHAVIOUR, 32'h0);
        // eleven faults overflow the history
        for (int i = 1; i <= 11; i++) begin
            fault(i[15:0], 3'(i % 5));
            check({16'h0, lastFaultNumber}, i);
            fault(16'h00ee, 3'h1);
            check({16'h0, lastFaultNumber}, i);
            pulse3(3'b010);
            check({16'h0, lastFaultNumber}, (i % 5 == 4) ? i : 0);
            pulse3(3'b100);
        end
        $display("test fill done");
        // readout after a power cycle, oldest first
        pulse3(3'b100);
        wr(fhm_pkg::ADDR_PTR_RESET, 32'h1, 1'b0);
        for (int i = 2; i <= 11; i++) begin
            rd(fhm_pkg::ADDR_ERR_NUM, i);
            rd(fhm_pkg::ADDR_CLASS, i % 5);
            rd(fhm_pkg::ADDR_TIME, {i[15:0], ~i[15:0]});
            rd(fhm_pkg::ADDR_EXTRA, i ^ 16'h5a5a);
        end
        rd(fhm_pkg::ADDR_ERR_NUM, 32'h0);
        wr(16'h0000, 32'h0, 1'b1); // unmapped
        wr(fhm_pkg::ADDR_CLASS, 32'h0, 1'b1);
        wr(fhm_pkg::ADDR_CLEAR, 32'h2, 1'b1);
        $display("test readout done");
        // bad realtime writes under both settings
        wr(fhm_pkg::ADDR_BEHAVIOUR, 32'h1, 1'b0);
        pulse3(3'b100);
        rd(fhm_pkg::ADDR_BEHAVIOUR, 32'h1);
        pulse3(3'b001);
        check({31'h0, rtWriteDiscard}, 32'h1);
        repeat (3) @(negedge clk);
        check({16'h0, lastFaultNumber}, 32'h1);
        check({31'h0, quickStop}, 32'h1);
        pulse3(3'b010);
        wr(fhm_pkg::ADDR_BEHAVIOUR, 32'h0, 1'b0);
        pulse3(3'b001);
        check({31'h0, rtWriteDiscard}, 32'h1);
        repeat (3) @(negedge clk);
        check({16'h0, lastFaultNumber}, 32'h0);
        check({31'h0, quickStop}, 32'h0);
        $display("test realtime done");
        // clear and poll until done
        wr(fhm_pkg::ADDR_CLEAR, 32'h1, 1'b0);
        rd(fhm_pkg::ADDR_CLEAR, 32'h1);
        for (int n = 0; n < 20 && d !== 32'h0; n++) begin
            fhm_master_model_i.access(1'b0, fhm_pkg::ADDR_CLEAR, 32'h0, d, er);
        end
        check(d, 32'h0);
        wr(fhm_pkg::ADDR_PTR_RESET, 32'h1, 1'b0);
        rd(fhm_pkg::ADDR_ERR_NUM, 32'h0);
        $display("test clear done");
        finish_test;
    end
endmodule : tb_fhm_fault_history
`default_nettype wire
